// *** hdl/fbmec_pkg.sv ***
// Shared constants, register map and types of the fieldbus mode/enable command block
package fbmec_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int FBMEC_IMG_W     = 64;
    localparam int FBMEC_POS_W     = 6;
    localparam int FBMEC_FW_W      = 5;
    localparam int FBMEC_MAX_FIELD = 16;
    localparam int FBMEC_VAL_W     = 8;
    localparam int FBMEC_NCMD      = 7;
    localparam int FBMEC_NLOAD     = 4;

    // ------------------------------------------------------------
    // Command indices and native ranges
    // ------------------------------------------------------------
    localparam int CMD_MODE        = 0;
    localparam int CMD_REL         = 1;
    localparam int CMD_SLOT        = 2;
    localparam int CMD_LOAD1       = 3;
    localparam int NATIVE_BIT      = 1;
    localparam int NATIVE_SLOT     = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_MAP_BASE = 8'h08;
    localparam logic [7:0] ADDR_MAP_LAST = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_REL_REQ_BIT   = 0;
    localparam int CTRL_TOOL_AUTO_BIT = 1;
    localparam int CTRL_TOOL_SET_BIT  = 2;
    localparam int STAT_AUTO_BIT      = 0;
    localparam int STAT_REL_BIT       = 1;
    localparam int STAT_TOOL_BIT      = 2;
    localparam int STAT_SLOT_LSB      = 8;
    localparam int MAP_EN_BIT         = 0;
    localparam int MAP_TGT_BIT        = 1;
    localparam int MAP_POS_LSB        = 8;
    localparam int MAP_WIDTH_LSB      = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       RST_REL_REQ = 1'b0;
    localparam logic       RST_RELEASE = 1'b0;
    localparam logic [7:0] RST_SLOT    = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic { FBMEC_TGT_CTRL, FBMEC_TGT_DRIVE } fbmec_target_t;
    typedef enum logic { FBMEC_MANUAL, FBMEC_AUTO } fbmec_mode_t;

    typedef struct packed {
        logic [FBMEC_FW_W-1:0]  width;
        logic [FBMEC_POS_W-1:0] pos;
        fbmec_target_t          target;
        logic                   en;
    } fbmec_map_t;

    typedef struct packed {
        logic                              valid;
        logic [FBMEC_NCMD-1:0]             sel;
        logic [FBMEC_NCMD*FBMEC_VAL_W-1:0] data;
    } fbmec_drv_cmd_t;

endpackage

// *** hdl/fbmec_sync.sv ***
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/1ps
`default_nettype none
module fbmec_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// *** hdl/fbmec_field.sv ***
// Extraction of one command field from the process image, scaled to its native range
`timescale 1ns/1ps
`default_nettype none
module fbmec_field
    import fbmec_pkg::*;
#(
    parameter int IMG_W  = FBMEC_IMG_W,
    parameter int NATIVE = NATIVE_BIT
) (
    // Process image and mapping
    input  wire logic [IMG_W-1:0] image,
    input  wire fbmec_map_t       map,
    // Value in native range, zero extended
    output logic [FBMEC_VAL_W-1:0] value
);
    if (NATIVE < 1 || NATIVE > FBMEC_VAL_W) begin : g_bad_native
        $error("fbmec_field: NATIVE out of range");
    end

    localparam logic [FBMEC_FW_W-1:0] MAXF = FBMEC_FW_W'(FBMEC_MAX_FIELD);
    localparam logic [FBMEC_FW_W-1:0] NATF = FBMEC_FW_W'(NATIVE);

    logic [FBMEC_MAX_FIELD-1:0] raw;
    logic [FBMEC_MAX_FIELD-1:0] masked;
    logic [FBMEC_FW_W-1:0]      w;

    always_comb begin
        w      = (map.width > MAXF) ? MAXF : map.width;
        raw    = FBMEC_MAX_FIELD'(image >> map.pos);
        masked = raw & ~({FBMEC_MAX_FIELD{1'b1}} << w);
        value  = '0;
        // A one-bit command counts any nonzero field as set
        if (w == '0) begin
            value = '0;
        end else if (NATIVE == 1) begin
            value = FBMEC_VAL_W'(|masked);
        end else if (w >= NATF) begin
            value = FBMEC_VAL_W'(masked >> (w - NATF));
        end else begin
            value = FBMEC_VAL_W'(masked << (NATF - w));
        end
    end
endmodule
`default_nettype wire

// *** hdl/fbmec_cmd_top.sv ***
// Fieldbus command interpreter: operating mode, global release, configuration loads
// How it works
// - Select zero: manual, only tool changes parameters.
// - Select nonzero: automatic, only fieldbus changes parameters.
// - Tool connected: fieldbus mode changes ignored.
// - Tool session closed: switch to automatic.
// - Every restart enters automatic mode.
// - Mapped select must be set for automatic.
// - Release low keeps power and back light off.
// - Unmapped release set on entering automatic unless rel_required is set.
// - Eight-bit selector loads the identified configuration.
// - Any command position, width up to 16 bits, scaled natively.
// - Commands routed to drive or main controller.
// - One-bit commands load slots one onward.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fbmec_cmd_top
    import fbmec_pkg::*;
#(
    parameter int IMG_W = FBMEC_IMG_W
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Fieldbus process image
    input  wire logic [IMG_W-1:0]      fb_image,
    input  wire logic                  fb_image_valid,
    // Configuration tool session
    input  wire logic                  tool_link_up,
    // Parameter ownership and mode
    output logic                       fb_param_en,
    output logic                       tool_param_en,
    output logic                       auto_active,
    // Power stage
    output logic                       power_en,
    output logic                       backlight_en,
    // Configuration load requests
    output logic                       cfg_load_req,
    output logic      [FBMEC_VAL_W-1:0] cfg_load_slot,
    // Commands forwarded to the feeder drive module
    output fbmec_drv_cmd_t             drv_cmd
);
    if (IMG_W < 1 || IMG_W > (1 << FBMEC_POS_W)) begin : g_bad_img
        $error("fbmec_cmd_top: IMG_W out of range");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fbmec_map_t             map_q   [FBMEC_NCMD];
    logic [FBMEC_VAL_W-1:0] cmd_val [FBMEC_NCMD];
    logic [FBMEC_VAL_W-1:0] cmd_prev[FBMEC_NCMD];
    logic [FBMEC_NCMD-1:0]  ctrl_map, drv_map;
    fbmec_mode_t            mode, next_mode;
    logic                   gen_release, next_release, rel_required, boot_q, entering_auto;
    logic                   tool_conn_s, tool_conn_d, tool_disc, tool_set;
    logic                   apb_acc, apb_wr, hit_ctrl, hit_status, hit_map;
    logic [2:0]             map_idx;
    logic [7:0]             map_off;
    logic                   fb_accept, slot_evt, load_evt;
    logic [FBMEC_NLOAD-1:0] bit_evt;
    logic [FBMEC_VAL_W-1:0] next_slot;
    logic [FBMEC_NCMD*FBMEC_VAL_W-1:0] next_drv_data;

    // ------------------------------------------------------------
    // Tool session pin
    // ------------------------------------------------------------
    fbmec_sync u_tool_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (tool_link_up),
        .q       (tool_conn_s)
    );
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tool_conn_d <= 1'b0;
        end else begin
            tool_conn_d <= tool_conn_s;
        end
    end
    assign tool_disc = tool_conn_d & ~tool_conn_s;

    // ------------------------------------------------------------
    // Field extraction, one per command
    // ------------------------------------------------------------
    for (genvar i = 0; i < FBMEC_NCMD; i++) begin : g_field
        localparam int NAT = (i == CMD_SLOT) ? NATIVE_SLOT : NATIVE_BIT;
        fbmec_field #(
            .IMG_W  (IMG_W),
            .NATIVE (NAT)
        ) u_field (
            .image (fb_image),
            .map   (map_q[i]),
            .value (cmd_val[i])
        );
        assign ctrl_map[i] = map_q[i].en && (map_q[i].width != '0)
                             && (map_q[i].target == FBMEC_TGT_CTRL);
        assign drv_map[i]  = map_q[i].en && (map_q[i].width != '0)
                             && (map_q[i].target == FBMEC_TGT_DRIVE);
    end

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign apb_acc    = psel & penable;
    assign apb_wr     = apb_acc & pwrite;
    assign map_off    = paddr - ADDR_MAP_BASE;
    assign map_idx    = map_off[4:2];
    assign hit_ctrl   = (paddr == ADDR_CTRL);
    assign hit_status = (paddr == ADDR_STATUS);
    assign hit_map    = (paddr >= ADDR_MAP_BASE) && (paddr <= ADDR_MAP_LAST)
                        && (paddr[1:0] == 2'b00);
    assign pready     = 1'b1;
    // Status is read-only, so a write to it is an error as well
    assign pslverr    = apb_acc & ~(hit_ctrl | hit_map | (hit_status & ~pwrite));
    assign tool_set   = apb_wr & hit_ctrl & pwdata[CTRL_TOOL_SET_BIT];

    always_comb begin
        prdata = '0;
        if (hit_ctrl) begin
            prdata[CTRL_REL_REQ_BIT]   = rel_required;
            prdata[CTRL_TOOL_AUTO_BIT] = (mode == FBMEC_AUTO);
        end else if (hit_status) begin
            prdata[STAT_AUTO_BIT]                         = (mode == FBMEC_AUTO);
            prdata[STAT_REL_BIT]                          = gen_release;
            prdata[STAT_TOOL_BIT]                         = tool_conn_s;
            prdata[STAT_SLOT_LSB +: FBMEC_VAL_W]          = cfg_load_slot;
        end else if (hit_map) begin
            prdata[MAP_EN_BIT]                            = map_q[map_idx].en;
            prdata[MAP_TGT_BIT]                           = map_q[map_idx].target;
            prdata[MAP_POS_LSB +: FBMEC_POS_W]            = map_q[map_idx].pos;
            prdata[MAP_WIDTH_LSB +: FBMEC_FW_W]           = map_q[map_idx].width;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rel_required <= RST_REL_REQ;
        end else if (apb_wr && hit_ctrl) begin
            rel_required <= pwdata[CTRL_REL_REQ_BIT];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            map_q <= '{default: '0};
        end else if (apb_wr && hit_map) begin
            map_q[map_idx].en     <= pwdata[MAP_EN_BIT];
            map_q[map_idx].target <= fbmec_target_t'(pwdata[MAP_TGT_BIT]);
            map_q[map_idx].pos    <= pwdata[MAP_POS_LSB +: FBMEC_POS_W];
            map_q[map_idx].width  <= pwdata[MAP_WIDTH_LSB +: FBMEC_FW_W];
        end
    end

    // ------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        if (tool_disc) begin
            next_mode = FBMEC_AUTO;
        end else if (tool_conn_s) begin
            // Only the tool may switch modes while its session is open
            if (tool_set) begin
                next_mode = pwdata[CTRL_TOOL_AUTO_BIT] ? FBMEC_AUTO : FBMEC_MANUAL;
            end
        end else if (fb_image_valid && ctrl_map[CMD_MODE]) begin
            next_mode = (cmd_val[CMD_MODE] != '0) ? FBMEC_AUTO : FBMEC_MANUAL;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode   <= FBMEC_AUTO;
            boot_q <= 1'b1;
        end else begin
            mode   <= next_mode;
            boot_q <= 1'b0;
        end
    end

    // Power-up counts as entering automatic mode
    assign entering_auto = (next_mode == FBMEC_AUTO) && ((mode == FBMEC_MANUAL) || boot_q);
    assign auto_active   = (mode == FBMEC_AUTO);
    assign fb_param_en   = (mode == FBMEC_AUTO);
    assign tool_param_en = (mode == FBMEC_MANUAL);

    // ------------------------------------------------------------
    // Global release and power stage
    // ------------------------------------------------------------
    always_comb begin
        next_release = gen_release;
        if (ctrl_map[CMD_REL]) begin
            if (fb_image_valid) begin
                next_release = cmd_val[CMD_REL][0];
            end
        end else if (rel_required) begin
            next_release = 1'b0;
        end else if (entering_auto) begin
            next_release = 1'b1;
        end
    end

    // Outputs follow the new release in the same update, never a cycle late
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gen_release  <= RST_RELEASE;
            power_en     <= RST_RELEASE;
            backlight_en <= RST_RELEASE;
        end else begin
            gen_release  <= next_release;
            power_en     <= next_release;
            backlight_en <= next_release;
        end
    end

    // ------------------------------------------------------------
    // Configuration loads
    // ------------------------------------------------------------
    // Loading is a parameter change, so the fieldbus may request it in automatic mode only
    assign fb_accept = fb_image_valid && (mode == FBMEC_AUTO);
    assign slot_evt  = fb_accept && ctrl_map[CMD_SLOT] && (cmd_val[CMD_SLOT] != '0)
                       && (cmd_val[CMD_SLOT] != cmd_prev[CMD_SLOT]);
    for (genvar k = 0; k < FBMEC_NLOAD; k++) begin : g_load
        assign bit_evt[k] = fb_accept && ctrl_map[CMD_LOAD1 + k]
                            && cmd_val[CMD_LOAD1 + k][0]
                            && !cmd_prev[CMD_LOAD1 + k][0];
    end
    assign load_evt = slot_evt | (|bit_evt);

    always_comb begin
        next_slot = cfg_load_slot;
        if (slot_evt) begin
            next_slot = cmd_val[CMD_SLOT];
        end else begin
            for (int k = FBMEC_NLOAD - 1; k >= 0; k--) begin
                if (bit_evt[k]) begin
                    next_slot = FBMEC_VAL_W'(k + 1);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_load_req  <= 1'b0;
            cfg_load_slot <= RST_SLOT;
        end else begin
            cfg_load_req  <= load_evt;
            cfg_load_slot <= next_slot;
        end
    end

    // Edges are judged between successive images, not between clock cycles
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cmd_prev <= '{default: '0};
        end else if (fb_image_valid) begin
            cmd_prev <= cmd_val;
        end
    end

    // ------------------------------------------------------------
    // Forwarding to the drive module
    // ------------------------------------------------------------
    always_comb begin
        next_drv_data = '0;
        for (int i = 0; i < FBMEC_NCMD; i++) begin
            next_drv_data[i*FBMEC_VAL_W +: FBMEC_VAL_W] = drv_map[i] ? cmd_val[i] : '0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            drv_cmd <= '0;
        end else begin
            drv_cmd.valid <= fb_image_valid && (|drv_map);
            if (fb_image_valid) begin
                drv_cmd.sel  <= drv_map;
                drv_cmd.data <= next_drv_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_slot_cmd;
        fb_image_valid && (mode == FBMEC_AUTO) && ctrl_map[CMD_SLOT]
        && (cmd_val[CMD_SLOT] != 8'h00) && (cmd_val[CMD_SLOT] != cmd_prev[CMD_SLOT]);
    endsequence
    sequence s_slot_load;
        cfg_load_req && (cfg_load_slot == $past(cmd_val[CMD_SLOT]));
    endsequence
    sequence s_release_drop;
        fb_image_valid && ctrl_map[CMD_REL] && !cmd_val[CMD_REL][0];
    endsequence

    property p_manual_owner;
        (mode == FBMEC_MANUAL) |-> (tool_param_en && !fb_param_en);
    endproperty
    a_manual_owner: assert property (p_manual_owner) else $error("manual owner wrong");
    property p_auto_owner;
        (mode == FBMEC_AUTO) |-> (fb_param_en && !tool_param_en);
    endproperty
    a_auto_owner: assert property (p_auto_owner) else $error("auto owner wrong");
    property p_tool_blocks;
        (tool_conn_s && !tool_set) |=> (mode == $past(mode));
    endproperty
    a_tool_blocks: assert property (p_tool_blocks) else $error("mode moved under tool");
    property p_disc_auto;
        tool_disc |=> auto_active;
    endproperty
    a_disc_auto: assert property (p_disc_auto) else $error("no auto on disconnect");
    property p_boot_auto;
        boot_q |-> (mode == FBMEC_AUTO);
    endproperty
    a_boot_auto: assert property (p_boot_auto) else $error("no auto after restart");
    property p_select_manual;
        (fb_image_valid && !tool_conn_s && !tool_conn_d && ctrl_map[CMD_MODE]
         && (cmd_val[CMD_MODE] == 8'h00)) |=> !auto_active;
    endproperty
    a_select_manual: assert property (p_select_manual) else $error("select zero kept auto");
    // Outputs may only come on through a mapped release or an entry into automatic mode
    property p_release_gate;
        (!gen_release && !entering_auto && !(fb_image_valid && ctrl_map[CMD_REL]))
        |=> (!power_en && !backlight_en);
    endproperty
    a_release_gate: assert property (p_release_gate) else $error("power on without release");
    property p_release_auto;
        (entering_auto && !ctrl_map[CMD_REL] && !rel_required) |=> gen_release && power_en;
    endproperty
    a_release_auto: assert property (p_release_auto) else $error("release not auto set");
    property p_slot_load;
        s_slot_cmd |=> s_slot_load;
    endproperty
    a_slot_load: assert property (p_slot_load) else $error("slot load missed");
    // Judged against the mapping that stood when the image was taken
    property p_drive_route;
        drv_cmd.valid |-> ((drv_cmd.sel & $past(ctrl_map)) == '0);
    endproperty
    a_drive_route: assert property (p_drive_route) else $error("controller cmd sent to drive");
    property p_bit_load;
        (bit_evt[0] && !slot_evt) |=> (cfg_load_req && (cfg_load_slot == 8'h01));
    endproperty
    a_bit_load: assert property (p_bit_load) else $error("slot one load missed");
    property p_release_drop;
        s_release_drop |=> (!power_en && !backlight_en);
    endproperty
    a_release_drop: assert property (p_release_drop) else $error("outputs late off");

endmodule
`default_nettype wire

// *** bench/fbmec_fb_master.sv ***
// Fieldbus master model: sends one process image per request
`timescale 1ns/1ps
`default_nettype none
module fbmec_fb_master (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Request from the bench
    input  wire logic        go,
    input  wire logic [63:0] img_in,
    // Process image towards the block
    output logic      [63:0] fb_image,
    output logic             fb_image_valid
);
    // Image is scrambled outside its valid cycle so the block cannot lean on it holding
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fb_image       <= 64'h0;
            fb_image_valid <= 1'b0;
        end else if (go) begin
            fb_image       <= img_in;
            fb_image_valid <= 1'b1;
        end else begin
            fb_image       <= ~fb_image;
            fb_image_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_fieldbus_mode_enable_commands.sv ***
// Self-checking bench of the fieldbus command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_mode_enable_commands;
    import fbmec_pkg::*;
    logic           clk_sys, reset, psel, penable, pwrite, go, tool_link_up;
    logic           pready, pslverr, err, fb_image_valid, cfg_load_req;
    logic           fb_param_en, tool_param_en, auto_active, power_en, backlight_en;
    logic [7:0]     paddr, cfg_load_slot;
    logic [31:0]    pwdata, prdata, rd;
    logic [63:0]    fb_image, img_in;
    fbmec_drv_cmd_t drv_cmd;
    int             fail_count = 0;
    int             cmp_count = 0;

    fbmec_cmd_top DUT (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fb_image, .fb_image_valid, .tool_link_up,
        .fb_param_en, .tool_param_en, .auto_active, .power_en, .backlight_en,
        .cfg_load_req, .cfg_load_slot, .drv_cmd);
    fbmec_fb_master u_master (.clk_sys, .reset, .go, .img_in, .fb_image, .fb_image_valid);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_mode(input logic a);
        chk("mode", {29'h0, a, a, ~a}, {29'h0, auto_active, fb_param_en, tool_param_en});
    endtask

    // Request held until pready is sampled high; no wait count assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Returns just after the edge at which the block takes the image
    task automatic img(input logic [63:0] v);
        @(posedge clk_sys);
        go     <= 1'b1;
        img_in <= v;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic t_reset;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_mode(1'b1);
        chk("power", 32'h3, {30'h0, power_en, backlight_en});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h3, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        $display("reset test done");
    endtask

    task automatic t_mode;
        apb(1'b1, ADDR_MAP_BASE, 32'h0008_0001);
        img(64'h0);
        chk_mode(1'b0);
        img(64'h4);
        chk_mode(1'b1);
        $display("mode test done");
    endtask

    task automatic t_tool;
        @(posedge clk_sys);
        tool_link_up <= 1'b1;
        repeat (3) @(posedge clk_sys);
        img(64'h0);
        chk_mode(1'b1);
        apb(1'b1, ADDR_CTRL, 32'h4);
        chk_mode(1'b0);
        img(64'h4);
        chk_mode(1'b0);
        @(posedge clk_sys);
        tool_link_up <= 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk_mode(1'b1);
        $display("tool test done");
    endtask

    task automatic t_rel;
        apb(1'b1, ADDR_MAP_BASE + 8'h04, 32'h0001_0801);
        img(64'h04);
        chk("power", 32'h0, {30'h0, power_en, backlight_en});
        img(64'h104);
        chk("power", 32'h3, {30'h0, power_en, backlight_en});
        $display("release test done");
    endtask

    task automatic t_slot;
        apb(1'b1, ADDR_MAP_BASE + 8'h08, 32'h0008_1001);
        img(64'h0003_0104);
        chk("load", 32'h103, {23'h0, cfg_load_req, cfg_load_slot});
        @(posedge clk_sys);
        #1;
        chk("load", 32'h003, {23'h0, cfg_load_req, cfg_load_slot});
        apb(1'b1, ADDR_MAP_BASE + 8'h0c, 32'h0001_1801);
        img(64'h0103_0104);
        chk("load", 32'h101, {23'h0, cfg_load_req, cfg_load_slot});
        apb(1'b1, ADDR_MAP_BASE + 8'h08, 32'h0004_1001);
        img(64'h0103_0104);
        chk("load", 32'h130, {23'h0, cfg_load_req, cfg_load_slot});
        $display("slot test done");
    endtask

    task automatic t_drv;
        apb(1'b1, ADDR_MAP_BASE + 8'h10, 32'h0001_2003);
        img(64'h1_0103_0104);
        chk("drv", 32'h90, {24'h0, drv_cmd.valid, drv_cmd.sel});
        chk("drv data", 32'h1, {24'h0, drv_cmd.data[39:32]});
        chk("load", 32'h0, {31'h0, cfg_load_req});
        $display("drive test done");
    endtask

    // Restart from manual mode must come back in automatic mode with the outputs released
    task automatic t_restart;
        img(64'h0);
        chk_mode(1'b0);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_mode(1'b1);
        chk("power", 32'h3, {30'h0, power_en, backlight_en});
        apb(1'b1, ADDR_CTRL, 32'h1);
        @(posedge clk_sys);
        #1;
        chk("power", 32'h0, {30'h0, power_en, backlight_en});
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        $display("restart test done");
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        {reset, psel, penable, pwrite, go, tool_link_up} = 6'h20;
        {paddr, pwdata, img_in} = '0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_mode();
        t_tool();
        t_rel();
        t_slot();
        t_drv();
        t_restart();
        finish_test();
    end

    // Tests need about a hundred cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
